// [asrp_pkg.sv]
// Constants, types and helpers shared by both ends of the converter
// serial register port.
// Assumes a SystemVerilog-2012 compiler; no other files are needed.
`default_nettype none
package asrp_pkg;
	// ------------------------------------------------------------
	// Widths and counts
	// ------------------------------------------------------------
	localparam int BYTE_W     = 8;
	localparam int DATA_W     = 16;
	localparam int WORD_W     = 24;
	localparam int CNT_W      = 5;
	localparam int ONES_W     = 6;
	localparam int ONES_RESET = 32;

	// ------------------------------------------------------------
	// Register select codes
	// ------------------------------------------------------------
	localparam logic [2:0] RS_COMM   = 3'h0;
	localparam logic [2:0] RS_SETUP  = 3'h1;
	localparam logic [2:0] RS_CLOCK  = 3'h2;
	localparam logic [2:0] RS_DATA   = 3'h3;
	localparam logic [2:0] RS_OFFSET = 3'h6;
	localparam logic [2:0] RS_GAIN   = 3'h7;

	// ------------------------------------------------------------
	// Communication register fields
	// ------------------------------------------------------------
	localparam int COMM_RDY_BIT  = 7;
	localparam int COMM_RS_LSB   = 4;
	localparam int COMM_RW_BIT   = 3;
	localparam int COMM_STBY_BIT = 2;
	localparam int COMM_CH_LSB   = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [BYTE_W-1:0] SETUP_RST = 8'h00;
	localparam logic [BYTE_W-1:0] CLOCK_RST = 8'h00;
	localparam logic [WORD_W-1:0] CAL_RST   = 24'h000000;

	// ------------------------------------------------------------
	// Host bring-up and polling words
	// ------------------------------------------------------------
	localparam logic [BYTE_W-1:0] HCMD_CLOCK_NEXT = 8'h20;
	localparam logic [BYTE_W-1:0] HCLOCK_WORD     = 8'h0c;
	localparam logic [BYTE_W-1:0] HCMD_SETUP_NEXT = 8'h10;
	localparam logic [BYTE_W-1:0] HSETUP_WORD     = 8'h40;
	localparam logic [BYTE_W-1:0] HCMD_READ_DATA  = 8'h38;
	localparam logic [BYTE_W-1:0] HCMD_READ_COMM  = 8'h08;
	localparam int                HOLDOFF         = 8;

	typedef enum logic [1:0] {
		PH_COMM  = 2'b00,
		PH_WRITE = 2'b01,
		PH_READ  = 2'b10
	} asrp_phase_t;

	// Index of the last bit of the access now in progress
	function automatic logic [CNT_W-1:0] asrp_last_bit(
		input asrp_phase_t ph,
		input logic [2:0]  rs
	);
		logic [CNT_W-1:0] n;
		n = 5'h07;
		if (ph != PH_COMM && rs == RS_DATA) begin
			n = 5'h0f;
		end else if (ph != PH_COMM && (rs == RS_OFFSET || rs == RS_GAIN)) begin
			n = 5'h17;
		end
		return n;
	endfunction : asrp_last_bit
endpackage : asrp_pkg
`default_nettype wire

// [asrp_link_if.sv]
// Serial link between the converter port and its host.
// Assumes the bench joins both ends; the output line has a pull-up.
`timescale 1ns/10ps
`default_nettype none
interface asrp_link_if;
	logic sclk;
	logic cs_n;
	logic din;
	logic dout;
	logic dout_oe;
	logic miso;
	logic sample_ready_n;

	// Pull-up on the output line while the device does not drive it
	assign miso = dout_oe ? dout : 1'b1;

	modport dev (
		input  sclk,
		input  cs_n,
		input  din,
		output dout,
		output dout_oe,
		output sample_ready_n
	);

	modport host (
		output sclk,
		output cs_n,
		output din,
		input  miso,
		input  sample_ready_n
	);
endinterface : asrp_link_if
`default_nettype wire

// [asrp_device.sv]
// Converter end of the serial register port: register file, framing,
// result buffer and sample-ready flag.
// Assumes the host drives sclk idling high; results arrive on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module asrp_device
	import asrp_pkg::*;
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// Serial link
	asrp_link_if.dev               link,
	// Result stream from the converter
	input  wire logic              res_valid,
	input  wire logic [DATA_W-1:0] res_data,
	output var  logic              res_ready,
	// Configuration towards the converter
	output var  logic [BYTE_W-1:0] cfg_setup,
	output var  logic [BYTE_W-1:0] cfg_clock,
	output var  logic [1:0]        cfg_channel,
	output var  logic              cfg_standby
);
	// ------------------------------------------------------------
	// State of the link domain
	// ------------------------------------------------------------
	typedef struct packed {
		asrp_phase_t       phase;
		logic [2:0]        rs;
		logic              rw;
		logic              stby;
		logic [1:0]        ch;
		logic [BYTE_W-1:0] setup;
		logic [BYTE_W-1:0] clock;
		logic [WORD_W-1:0] offset;
		logic [WORD_W-1:0] gain;
		logic [WORD_W-1:0] shin;
		logic [WORD_W-1:0] shout;
		logic [ONES_W-1:0] ones;
		logic [DATA_W-1:0] data_cap;
		logic [1:0]        upd_sync;
		logic              upd_seen;
		logic [1:0]        rdy_sync;
		logic              rd_tgl;
		logic              cfg_tgl;
	} asrp_link_t;

	// ------------------------------------------------------------
	// State of the core domain
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0][DATA_W-1:0] fifo;
		logic                   head;
		logic [1:0]             count;
		logic                   in_ready;
		logic [DATA_W-1:0]      data;
		logic                   rdy_n;
		logic                   upd_tgl;
		logic [1:0]             rd_sync;
		logic                   rd_seen;
		logic [1:0]             cfg_sync;
		logic                   cfg_seen;
		logic [BYTE_W-1:0]      setup;
		logic [BYTE_W-1:0]      clock;
		logic [1:0]             ch;
		logic                   stby;
	} asrp_core_t;

	localparam asrp_link_t LINK_RST = '{
		phase: PH_COMM, rs: RS_COMM, setup: SETUP_RST, clock: CLOCK_RST,
		offset: CAL_RST, gain: CAL_RST, rdy_sync: 2'h3, default: '0};
	localparam asrp_core_t CORE_RST = '{
		in_ready: 1'b1, rdy_n: 1'b1, setup: SETUP_RST, clock: CLOCK_RST,
		default: '0};

	asrp_link_t       lk_reg;
	asrp_link_t       lk_next;
	asrp_core_t       cr_reg;
	asrp_core_t       cr_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             dout_reg;
	logic             oe_reg;
	logic             frame_rst_n;

	// Bit count and output restart whenever select is released; the phase is kept
	assign frame_rst_n = rst_n & ~link.cs_n;

	// ------------------------------------------------------------
	// Link domain: shifting and register access
	// ------------------------------------------------------------
	always_comb begin : link_next_c
		logic [BYTE_W-1:0] byte_in;
		logic [WORD_W-1:0] word_in;
		logic [DATA_W-1:0] dword;
		logic              last;
		lk_next  = lk_reg;
		cnt_next = CNT_W'(cnt_reg + 1'b1);
		byte_in  = {lk_reg.shin[BYTE_W-2:0], link.din};
		word_in  = {lk_reg.shin[WORD_W-2:0], link.din};
		dword    = lk_reg.data_cap;
		last     = (cnt_reg == asrp_last_bit(lk_reg.phase, lk_reg.rs));
		lk_next.upd_sync = {lk_reg.upd_sync[0], cr_reg.upd_tgl};
		lk_next.rdy_sync = {lk_reg.rdy_sync[0], cr_reg.rdy_n};
		if (lk_reg.upd_sync[1] != lk_reg.upd_seen) begin
			lk_next.upd_seen = lk_reg.upd_sync[1];
			lk_next.data_cap = cr_reg.data;
			dword            = cr_reg.data;
		end
		if (!link.cs_n) begin
			if (lk_reg.phase != PH_READ) begin
				lk_next.shin = word_in;
				lk_next.ones = link.din ? ONES_W'(lk_reg.ones + 1'b1) : '0;
			end
			unique case (lk_reg.phase)
				PH_COMM: begin
					if (last) begin
						cnt_next = '0;
						if (!byte_in[COMM_RDY_BIT]) begin
							lk_next.rs   = byte_in[COMM_RS_LSB +: 3];
							lk_next.rw   = byte_in[COMM_RW_BIT];
							lk_next.stby = byte_in[COMM_STBY_BIT];
							lk_next.ch   = byte_in[COMM_CH_LSB +: 2];
							lk_next.cfg_tgl = ~lk_reg.cfg_tgl;
							// Next clocks belong to the chosen register
							if (byte_in[COMM_RW_BIT]) begin
								lk_next.phase = PH_READ;
							end else if (byte_in[COMM_RS_LSB +: 3] != RS_COMM) begin
								lk_next.phase = PH_WRITE;
							end
							unique case (byte_in[COMM_RS_LSB +: 3])
								RS_COMM: lk_next.shout = {lk_reg.rdy_sync[1],
									byte_in[BYTE_W-2:0], 16'h0000};
								RS_SETUP:  lk_next.shout = {lk_reg.setup, 16'h0000};
								RS_CLOCK:  lk_next.shout = {lk_reg.clock, 16'h0000};
								RS_DATA:   lk_next.shout = {dword, 8'h00};
								RS_OFFSET: lk_next.shout = lk_reg.offset;
								RS_GAIN:   lk_next.shout = lk_reg.gain;
								default:   lk_next.shout = '0;
							endcase
						end
					end
				end
				PH_WRITE: begin
					if (last) begin
						cnt_next      = '0;
						lk_next.phase = PH_COMM;
						unique case (lk_reg.rs)
							RS_SETUP:  lk_next.setup  = byte_in;
							RS_CLOCK:  lk_next.clock  = byte_in;
							RS_OFFSET: lk_next.offset = word_in;
							RS_GAIN:   lk_next.gain   = word_in;
							default:   lk_next.phase  = PH_COMM;
						endcase
						lk_next.cfg_tgl = ~lk_reg.cfg_tgl;
					end
				end
				PH_READ: begin
					// Input line is not looked at while reading
					lk_next.shout = {lk_reg.shout[WORD_W-2:0], 1'b0};
					if (last) begin
						cnt_next      = '0;
						lk_next.phase = PH_COMM;
						if (lk_reg.rs == RS_DATA) begin
							lk_next.rd_tgl = ~lk_reg.rd_tgl;
						end
					end
				end
				default: begin
					cnt_next      = '0;
					lk_next.phase = PH_COMM;
				end
			endcase
			// Run of ones brings framing back to the command byte
			if (lk_reg.phase != PH_READ && link.din &&
				lk_reg.ones == ONES_W'(ONES_RESET - 1)) begin
				cnt_next      = '0;
				lk_next.phase = PH_COMM;
				lk_next.ones  = '0;
			end
		end
	end : link_next_c

	always_ff @(posedge link.sclk or negedge rst_n) begin
		if (!rst_n) begin
			lk_reg <= LINK_RST;
		end else begin
			lk_reg <= lk_next;
		end
	end

	always_ff @(posedge link.sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Output bit changes on the falling edge, host samples on rising
	always_ff @(negedge link.sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			dout_reg <= 1'b0;
			oe_reg   <= 1'b0;
		end else begin
			dout_reg <= lk_reg.shout[WORD_W-1];
			oe_reg   <= (lk_reg.phase == PH_READ);
		end
	end

	// ------------------------------------------------------------
	// Core domain: result buffer, ready flag, configuration copy
	// ------------------------------------------------------------
	always_comb begin : core_next_c
		logic push;
		logic pop;
		cr_next  = cr_reg;
		push     = res_valid & cr_reg.in_ready;
		// A new word is taken only once the last one was read out
		pop      = (cr_reg.count != 2'h0) & cr_reg.rdy_n;
		cr_next.rd_sync  = {cr_reg.rd_sync[0], lk_reg.rd_tgl};
		cr_next.cfg_sync = {cr_reg.cfg_sync[0], lk_reg.cfg_tgl};
		if (cr_reg.rd_sync[1] != cr_reg.rd_seen) begin
			cr_next.rd_seen = cr_reg.rd_sync[1];
			cr_next.rdy_n   = 1'b1;
		end
		if (pop) begin
			cr_next.data    = cr_reg.fifo[cr_reg.head];
			cr_next.head    = ~cr_reg.head;
			cr_next.upd_tgl = ~cr_reg.upd_tgl;
			cr_next.rdy_n   = 1'b0;
		end
		if (push) begin
			cr_next.fifo[cr_reg.head ^ cr_reg.count[0]] = res_data;
		end
		cr_next.count    = 2'(cr_reg.count + push - pop);
		cr_next.in_ready = (cr_next.count != 2'h2);
		if (cr_reg.cfg_sync[1] != cr_reg.cfg_seen) begin
			cr_next.cfg_seen = cr_reg.cfg_sync[1];
			cr_next.setup    = lk_reg.setup;
			cr_next.clock    = lk_reg.clock;
			cr_next.ch       = lk_reg.ch;
			cr_next.stby     = lk_reg.stby;
		end
	end : core_next_c

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cr_reg <= CORE_RST;
		end else begin
			cr_reg <= cr_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.dout           = dout_reg;
	assign link.dout_oe        = oe_reg;
	assign link.sample_ready_n = cr_reg.rdy_n;
	assign res_ready           = cr_reg.in_ready;
	assign cfg_setup           = cr_reg.setup;
	assign cfg_clock           = cr_reg.clock;
	assign cfg_channel         = cr_reg.ch;
	assign cfg_standby         = cr_reg.stby;
endmodule : asrp_device
`default_nettype wire

// [asrp_host.sv]
// Host end of the converter serial port: makes the serial clock,
// runs the bring-up sequence and gathers results.
// Assumes the converter end is joined through asrp_link_if.
`timescale 1ns/10ps
`default_nettype none
module asrp_host
	import asrp_pkg::*;
#(
	parameter int HALF        = 4,
	parameter int NUM_SAMPLES = 1000
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// Serial link
	asrp_link_if.host              link,
	// Control
	input  wire logic              start,
	input  wire logic              poll_status,
	output var  logic              busy,
	output var  logic              done,
	// Samples out
	output var  logic              smp_valid,
	output var  logic [DATA_W-1:0] smp_data,
	input  wire logic              smp_ready
);
	// Divider needs room for the two-stage input syncs; counters are sized
	if (HALF < 3 || HALF > 127 ||
		NUM_SAMPLES < 1 || NUM_SAMPLES > 65535) begin : g_param_chk
		$error("asrp_host: unsupported parameter value");
	end

	localparam logic [7:0]  HALF_C = 8'(HALF);
	localparam logic [7:0]  LAST_C = 8'(2 * HALF - 1);
	localparam logic [15:0] NUM_C  = 16'(NUM_SAMPLES);

	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_XFER = 3'b001,
		HS_WAIT = 3'b010,
		HS_PUSH = 3'b011,
		HS_DONE = 3'b100
	} asrp_hstate_t;

	typedef struct packed {
		asrp_hstate_t      state;
		logic [2:0]        step;
		logic              sclk;
		logic              cs_n;
		logic              mosi;
		logic              rx;
		logic [15:0]       sh;
		logic [4:0]        nbits;
		logic [7:0]        div;
		logic [1:0]        miso_sync;
		logic [1:0]        rdy_sync;
		logic [15:0]       cnt;
		logic              smp_valid;
		logic [DATA_W-1:0] smp_data;
		logic              busy;
		logic              done;
	} asrp_host_t;

	localparam asrp_host_t HOST_RST = '{state: HS_IDLE, sclk: 1'b1,
		cs_n: 1'b1, mosi: 1'b1, miso_sync: 2'h3, rdy_sync: 2'h3,
		default: '0};

	asrp_host_t h_reg;
	asrp_host_t h_next;

	// Word sent at each step of the sequence
	function automatic logic [BYTE_W-1:0] step_word(input logic [2:0] s);
		unique case (s)
			3'h0:    return HCMD_CLOCK_NEXT;
			3'h1:    return HCLOCK_WORD;
			3'h2:    return HCMD_SETUP_NEXT;
			3'h3:    return HSETUP_WORD;
			3'h4:    return HCMD_READ_COMM;
			3'h6:    return HCMD_READ_DATA;
			default: return 8'hff;
		endcase
	endfunction : step_word

	// Opens a transfer for the given step; clock rests high
	function automatic asrp_host_t begin_xfer(
		input asrp_host_t h,
		input logic [2:0] s
	);
		asrp_host_t r;
		r       = h;
		r.state = HS_XFER;
		r.step  = s;
		r.cs_n  = 1'b0;
		r.sclk  = 1'b1;
		r.div   = '0;
		r.rx    = (s == 3'h5) || (s == 3'h7);
		r.nbits = (s == 3'h7) ? 5'h10 : 5'h08;
		r.sh    = {step_word(s), 8'hff};
		return r;
	endfunction : begin_xfer

	always_comb begin
		h_next           = h_reg;
		h_next.done      = 1'b0;
		h_next.miso_sync = {h_reg.miso_sync[0], link.miso};
		h_next.rdy_sync  = {h_reg.rdy_sync[0], link.sample_ready_n};
		unique case (h_reg.state)
			HS_IDLE: begin
				if (start) begin
					h_next      = begin_xfer(h_reg, 3'h0);
					h_next.busy = 1'b1;
					h_next.cnt  = '0;
				end
			end
			HS_XFER: begin
				h_next.div = 8'(h_reg.div + 1'b1);
				if (h_reg.div == 8'h00) begin
					h_next.sclk = 1'b0;
					h_next.mosi = h_reg.rx ? 1'b1 : h_reg.sh[15];
				end else if (h_reg.div == HALF_C) begin
					h_next.sclk = 1'b1;
					h_next.sh   = {h_reg.sh[14:0], h_reg.miso_sync[1]};
				end else if (h_reg.div == LAST_C) begin
					h_next.div   = '0;
					h_next.nbits = 5'(h_reg.nbits - 1'b1);
					if (h_reg.nbits == 5'h01) begin
						h_next.cs_n = 1'b1;
						h_next.mosi = 1'b1;
						unique case (h_reg.step)
							3'h3: h_next.state = HS_WAIT;
							3'h5: h_next = begin_xfer(h_reg,
								h_reg.sh[COMM_RDY_BIT] ? 3'h4 : 3'h6);
							3'h7: begin
								h_next.state     = HS_PUSH;
								h_next.smp_valid = 1'b1;
								h_next.smp_data  = h_reg.sh;
							end
							default: h_next = begin_xfer(h_reg, 3'(h_reg.step + 1'b1));
						endcase
					end
				end
			end
			HS_WAIT: begin
				// Holdoff lets a stale ready level drain through the syncs
				if (h_reg.div != 8'(HOLDOFF)) begin
					h_next.div = 8'(h_reg.div + 1'b1);
				end else if (poll_status) begin
					h_next = begin_xfer(h_reg, 3'h4);
				end else if (!h_reg.rdy_sync[1]) begin
					h_next = begin_xfer(h_reg, 3'h6);
				end
			end
			HS_PUSH: begin
				if (smp_ready) begin
					h_next.smp_valid = 1'b0;
					h_next.cnt       = 16'(h_reg.cnt + 1'b1);
					h_next.div       = '0;
					h_next.state = (h_reg.cnt == 16'(NUM_C - 1'b1)) ?
						HS_DONE : HS_WAIT;
				end
			end
			HS_DONE: begin
				h_next.state = HS_IDLE;
				h_next.busy  = 1'b0;
				h_next.done  = 1'b1;
			end
			default: h_next = HOST_RST;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			h_reg <= HOST_RST;
		end else begin
			h_reg <= h_next;
		end
	end

	assign link.sclk = h_reg.sclk;
	assign link.cs_n = h_reg.cs_n;
	assign link.din  = h_reg.mosi;
	assign busy      = h_reg.busy;
	assign done      = h_reg.done;
	assign smp_valid = h_reg.smp_valid;
	assign smp_data  = h_reg.smp_data;
endmodule : asrp_host
`default_nettype wire

// [asrp_link_sva.sv]
// Concurrent checks on the serial link between host and converter ends.
// Assumes the bench wires it beside the link interface instance.
`timescale 1ns/10ps
`default_nettype none
module asrp_link_sva
	import asrp_pkg::*;
#(
	parameter int HALF = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Link lines
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic miso,
	input wire logic sample_ready_n
);
	logic       sclk_q;
	logic [5:0] rise_cnt;
	logic [3:0] low_run;

	// Shortest low half that keeps a frame-mode clock slow enough
	localparam int MIN_HALF = 7;

	// ------------------------------------------------------------
	// Rising edges within a frame, length of each low half
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q   <= 1'b1;
			rise_cnt <= 6'h00;
			low_run  <= 4'h0;
		end else begin
			sclk_q   <= sclk;
			rise_cnt <= cs_n ? 6'h00 : rise_cnt + {5'h00, sclk & ~sclk_q};
			low_run  <= sclk ? 4'h0 : low_run + 4'h1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// Link properties
	// ------------------------------------------------------------
	property p_sclk_idle;
		cs_n |-> sclk;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle)
		else $error("serial clock low while deselected");
	property p_sclk_half;
		$rose(sclk) |-> low_run == 4'(HALF);
	endproperty
	a_sclk_half: assert property (p_sclk_half)
		else $error("serial clock low half has wrong length");
	property p_desel_quiet;
		cs_n |-> !dout_oe && miso;
	endproperty
	a_desel_quiet: assert property (p_desel_quiet)
		else $error("output driven while deselected");
	property p_oe_on_fall;
		$rose(dout_oe) |-> $fell(sclk) && !cs_n;
	endproperty
	a_oe_on_fall: assert property (p_oe_on_fall)
		else $error("output enable rose away from a falling edge");
	property p_oe_at_byte;
		$rose(dout_oe) |-> rise_cnt[2:0] == 3'h0;
	endproperty
	a_oe_at_byte: assert property (p_oe_at_byte)
		else $error("read began inside a byte");
	property p_dout_stable;
		dout_oe && $past(dout_oe) && !$fell(sclk) |-> $stable(dout);
	endproperty
	a_dout_stable: assert property (p_dout_stable)
		else $error("output bit changed away from a falling edge");
	property p_frame_bytes;
		$rose(cs_n) |-> rise_cnt != 6'h00 && rise_cnt[2:0] == 3'h0;
	endproperty
	a_frame_bytes: assert property (p_frame_bytes)
		else $error("frame not a whole number of bytes");
	property p_ready_hold;
		$fell(sample_ready_n) |=> !sample_ready_n [*8];
	endproperty
	a_ready_hold: assert property (p_ready_hold)
		else $error("sample ready released without a read");
	property p_sclk_rate;
		$rose(sclk) |-> low_run >= 4'(MIN_HALF);
	endproperty
	a_sclk_rate: assert property (p_sclk_rate)
		else $error("serial clock faster than the frame-mode limit");
	property p_din_read_idle;
		dout_oe |-> din;
	endproperty
	a_din_read_idle: assert property (p_din_read_idle)
		else $error("host drove input data during a read");
endmodule : asrp_link_sva
`default_nettype wire

// [adc_serial_register_port_bench.sv]
// Bench joining host and converter ends; feeds results, takes samples.
// Assumes package, interface, both ends and checker compiled first.
`timescale 1ns/10ps
`default_nettype none
module adc_serial_register_port_bench
	import asrp_pkg::*;
;
	localparam int HALF  = 7;
	localparam int LIMIT = 20000;
	localparam logic [DATA_W-1:0] CORNER [3] = '{16'hffff, 16'h0000, 16'h8001};

	logic              ref_clk     = 1'b0;
	logic              rst_n       = 1'b0;
	logic              start       = 1'b0;
	logic              poll_status = 1'b0;
	logic              smp_ready   = 1'b0;
	logic              res_valid   = 1'b0;
	logic [DATA_W-1:0] res_data    = 16'h0000;
	logic              busy, done, smp_valid, res_ready, cfg_standby;
	logic [DATA_W-1:0] smp_data;
	logic [BYTE_W-1:0] cfg_setup, cfg_clock;
	logic [1:0]        cfg_channel;
	int                fail_count  = 0;
	int                tests_run   = 0;
	int                seed        = 32'h643cd06d;
	logic [DATA_W-1:0] exp_q [$];

	// ------------------------------------------------------------
	// Both ends, the link and its checker
	// ------------------------------------------------------------
	asrp_link_if link ();
	asrp_device asrp_device_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.link(link), .res_valid(res_valid), .res_data(res_data),
		.res_ready(res_ready), .cfg_setup(cfg_setup),
		.cfg_clock(cfg_clock), .cfg_channel(cfg_channel),
		.cfg_standby(cfg_standby));
	asrp_host #(.HALF(HALF), .NUM_SAMPLES(3)) asrp_host_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .start(start),
		.poll_status(poll_status), .busy(busy), .done(done),
		.smp_valid(smp_valid), .smp_data(smp_data),
		.smp_ready(smp_ready));
	asrp_link_sva #(.HALF(HALF)) asrp_link_sva_inst (.ref_clk(ref_clk),
		.rst_n(rst_n), .sclk(link.sclk), .cs_n(link.cs_n),
		.din(link.din), .dout(link.dout), .dout_oe(link.dout_oe),
		.miso(link.miso), .sample_ready_n(link.sample_ready_n));

	always #12.5 ref_clk = ~ref_clk;

	// Sample sink stalls at random
	always @(posedge ref_clk) begin
		smp_ready <= ($random(seed) & 3) != 0;
	end

	// Samples must leave in the order the results entered
	always @(negedge ref_clk) begin
		if (smp_valid === 1'b1 && smp_ready === 1'b1) begin
			check(32'(smp_data), 32'(exp_q.pop_front()));
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("counts: compares=%0d mismatches=%0d", tests_run,
			fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic tick_limit(inout int i);
		@(negedge ref_clk);
		i++;
		if (i > LIMIT) begin
			fail_count++;
			print_verdict();
		end
	endtask : tick_limit

	// Called at a rising edge; leaves valid high for a following word
	task automatic send(input logic [DATA_W-1:0] w);
		int i;
		i = 0;
		res_valid <= 1'b1;
		res_data  <= w;
		@(negedge ref_clk);
		while (res_ready !== 1'b1) begin
			tick_limit(i);
		end
		@(posedge ref_clk);
		exp_q.push_back(w);
	endtask : send

	task automatic run(input logic mode);
		int i;
		i = 0;
		@(posedge ref_clk);
		poll_status <= mode;
		start       <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		@(negedge ref_clk);
		check(32'(busy), 32'h1);
		while (done !== 1'b1) begin
			tick_limit(i);
		end
		check(32'(busy), 32'h0);
		check(32'(cfg_channel), 32'h0);
		check(32'(cfg_standby), 32'h0);
		check(32'(cfg_clock), 32'(HCLOCK_WORD));
		check(32'(cfg_setup), 32'(HSETUP_WORD));
		check(32'(exp_q.size()), 32'h0);
	endtask : run

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		// Back-to-back words fill the result register and the buffer
		for (int k = 0; k < 3; k++) begin
			send(CORNER[k]);
		end
		res_valid <= 1'b0;
		repeat (4) @(negedge ref_clk);
		check(32'(link.sample_ready_n), 32'h0);
		check(32'(res_ready), 32'h0);
		$display("test buffer fill done");
		run(1'b1);
		repeat (8) @(negedge ref_clk);
		check(32'(link.sample_ready_n), 32'h1);
		check(32'(res_ready), 32'h1);
		$display("test status poll run done");
		fork
			run(1'b0);
			for (int k = 0; k < 3; k++) begin
				repeat (1 + ($random(seed) & 15)) @(posedge ref_clk);
				send(16'($random(seed)));
				res_valid <= 1'b0;
			end
		join
		$display("test pin watch run done");
		print_verdict();
	end
endmodule : adc_serial_register_port_bench
`default_nettype wire
